// ===== tsp_slave_port.sv
/*
 two-wire slave port: decodes START/STOP, matches the bus address,
 keeps an auto-incrementing register pointer and moves bytes to and
 from the register file through req_o / rdata_i.
 assumes the register file answers rdata_i combinationally from
 req_o.addr; bus clock up to 400 kHz, core clock 250 MHz.
*/
module tsp_slave_port
   import tsp_pkg::*;
(
   input  wire logic       mclk_i,   // core clock, 250 MHz
   input  wire logic       rstn_i,   // sync reset, active low
   input  wire logic       scl_i,    // bus clock pin
   input  wire logic       sda_i,    // bus data pin, input side
   output logic            sda_o,    // bus data out, always low
   output logic            sda_oe_o, // high while pulling sda low
   output tsp_reg_req_s    req_o,    // register access request
   input  wire logic [7:0] rdata_i,  // register read data
   output logic            busy_o    // transfer in progress
);
   // ****************************************
   // line sampling
   // ****************************************
   logic scl_lvl, scl_rise, scl_fall;
   logic sda_lvl, sda_rise, sda_fall;

   tsp_sync u_scl (
      .mclk_i  (mclk_i),
      .rstn_i  (rstn_i),
      .line_i  (scl_i),
      .level_o (scl_lvl),
      .rise_o  (scl_rise),
      .fall_o  ()
   );

   tsp_sync u_sda (
      .mclk_i  (mclk_i),
      .rstn_i  (rstn_i),
      .line_i  (sda_i),
      .level_o (sda_lvl),
      .rise_o  (sda_rise),
      .fall_o  (sda_fall)
   );

   logic scl_dly_q;
   always_ff @(posedge mclk_i) begin
      if (!rstn_i)
         scl_dly_q <= 1'b1;
      else
         scl_dly_q <= scl_lvl;
   end
   assign scl_fall = scl_dly_q & ~scl_lvl;

   logic start_ev, stop_ev;
   assign start_ev = sda_fall & scl_lvl;
   assign stop_ev  = sda_rise & scl_lvl;

   // ****************************************
   // protocol state
   // ****************************************
   tsp_state_e   state_q, state_d;
   logic [3:0]   bit_q, bit_d;
   logic [7:0]   shift_q, shift_d;
   logic [7:0]   ptr_q, ptr_d;
   logic         drive_q, drive_d;
   logic         nack_q, nack_d;
   tsp_reg_req_s req_q, req_d;

   always_comb begin
      state_d = state_q;
      bit_d   = bit_q;
      shift_d = shift_q;
      ptr_d   = ptr_q;
      drive_d = drive_q;
      nack_d  = nack_q;
      req_d   = '0;
      req_d.addr  = ptr_q;
      req_d.wdata = shift_q;
      if (stop_ev) begin
         state_d = TSP_IDLE;
         drive_d = 1'b0;
      end else if (start_ev) begin
         state_d = TSP_ADDR;
         bit_d   = 4'h0;
         drive_d = 1'b0;
      end else if (scl_rise) begin
         case (state_q)
            TSP_ADDR, TSP_PTR, TSP_WDATA: begin
               shift_d = {shift_q[6:0], sda_lvl};
               bit_d   = bit_q + 4'h1;
            end
            TSP_RDATA_ACK: begin
               nack_d = sda_lvl;
            end
            default: begin
               bit_d = bit_q;
            end
         endcase
      end else if (scl_fall) begin
         case (state_q)
            TSP_ADDR: begin
               if (bit_q == TSP_ACK_SLOT) begin
                  if (shift_q[7:1] == TSP_DEV_ADDR) begin
                     state_d = TSP_ADDR_ACK;
                     drive_d = 1'b1;
                  end else begin
                     state_d = TSP_IGNORE;
                  end
               end
            end
            TSP_ADDR_ACK: begin
               bit_d = 4'h0;
               if (shift_q[TSP_DIR_BIT]) begin
                  state_d = TSP_RDATA;
                  shift_d = rdata_i;
                  req_d.rd = 1'b1;
                  drive_d = ~rdata_i[7];
                  bit_d   = 4'h1;
               end else begin
                  state_d = TSP_PTR;
                  drive_d = 1'b0;
               end
            end
            TSP_PTR, TSP_WDATA: begin
               if (bit_q == TSP_ACK_SLOT) begin
                  drive_d = 1'b1;
                  state_d = (state_q == TSP_PTR) ? TSP_PTR_ACK
                                                 : TSP_WDATA_ACK;
                  if (state_q == TSP_PTR) begin
                     ptr_d = shift_q;
                  end else begin
                     req_d.wr = 1'b1;
                     ptr_d    = ptr_q + 8'h01;
                  end
               end
            end
            TSP_PTR_ACK, TSP_WDATA_ACK: begin
               state_d = TSP_WDATA;
               bit_d   = 4'h0;
               drive_d = 1'b0;
            end
            TSP_RDATA: begin
               if (bit_q == TSP_ACK_SLOT) begin
                  state_d = TSP_RDATA_ACK;
                  drive_d = 1'b0;
                  ptr_d   = ptr_q + 8'h01;
               end else begin
                  drive_d = ~shift_q[3'(7 - bit_q)];
                  bit_d   = bit_q + 4'h1;
               end
            end
            TSP_RDATA_ACK: begin
               if (nack_q) begin
                  state_d = TSP_IGNORE;
                  drive_d = 1'b0;
               end else begin
                  state_d  = TSP_RDATA;
                  shift_d  = rdata_i;
                  req_d.rd = 1'b1;
                  drive_d  = ~rdata_i[7];
                  bit_d    = 4'h1;
               end
            end
            default: begin
               drive_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         state_q <= TSP_IDLE;
         bit_q   <= 4'h0;
         shift_q <= TSP_BYTE_RESET;
         ptr_q   <= TSP_PTR_RESET;
         drive_q <= 1'b0;
         nack_q  <= 1'b0;
         req_q   <= '0;
      end else begin
         state_q <= state_d;
         bit_q   <= bit_d;
         shift_q <= shift_d;
         ptr_q   <= ptr_d;
         drive_q <= drive_d;
         nack_q  <= nack_d;
         req_q   <= req_d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // open-drain data
   assign sda_o    = 1'b0;
   assign sda_oe_o = drive_q;
   assign req_o    = req_q;
   assign busy_o   = (state_q != TSP_IDLE);
endmodule

// ===== tsp_pkg.sv
/*
 two-wire slave port package: bus address, byte layout, timing figures
 and the register-side carrier shared by the port modules.
 assumes a 250 MHz core clock and a bus clock of at most 400 kHz.
*/
package tsp_pkg;
   // ****************************************
   // addressing and byte layout
   // ****************************************
   localparam logic [6:0] TSP_DEV_ADDR   = 7'h35;
   localparam int         TSP_DIR_BIT    = 0;
   localparam logic [3:0] TSP_ACK_SLOT   = 4'h8;
   localparam logic [7:0] TSP_PTR_RESET  = 8'h00;
   localparam logic [7:0] TSP_BYTE_RESET = 8'h00;
   localparam logic [1:0] TSP_SYNC_RESET = 2'h3;

   // ****************************************
   // timing figures
   // ****************************************
   localparam int TSP_CLK_MHZ     = 250;
   localparam int TSP_FAST_KHZ    = 400;
   localparam int TSP_MIN_HALF_CY = (TSP_CLK_MHZ * 1000) / (2 * TSP_FAST_KHZ);

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tsp_reg_req_s;

   typedef enum {
      TSP_IDLE,
      TSP_ADDR,
      TSP_ADDR_ACK,
      TSP_PTR,
      TSP_PTR_ACK,
      TSP_WDATA,
      TSP_WDATA_ACK,
      TSP_RDATA,
      TSP_RDATA_ACK,
      TSP_IGNORE
   } tsp_state_e;
endpackage

// ===== tsp_sync.sv
/*
 two-stage synchroniser with edge flags for one bus line.
 assumes the line is asynchronous to mclk_i; idles high.
*/
module tsp_sync
   import tsp_pkg::*;
(
   input  wire logic mclk_i,   // core clock
   input  wire logic rstn_i,   // sync reset, active low
   input  wire logic line_i,   // raw bus line
   output logic      level_o,  // synchronised level
   output logic      rise_o,   // rising edge pulse
   output logic      fall_o    // falling edge pulse
);
   logic [1:0] sync_q, sync_d;
   logic       last_q, last_d;

   always_comb begin
      sync_d = {sync_q[0], line_i};
      last_d = sync_q[1];
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         sync_q <= TSP_SYNC_RESET;
         last_q <= 1'b1;
      end else begin
         sync_q <= sync_d;
         last_q <= last_d;
      end
   end

   assign level_o = sync_q[1];
   assign rise_o  = sync_q[1] & ~last_q;
   assign fall_o  = ~sync_q[1] & last_q;
endmodule

// ===== tsp_props.sv
/* checker on the slave port pins and request strobes.
 assumes a bind onto tsp_slave_port; sees only its ports. */
module tsp_props
   import tsp_pkg::*;
(
   input  wire logic         mclk_i,   // core clock
   input  wire logic         rstn_i,   // sync reset, active low
   input  wire logic         scl_i,    // bus clock pin
   input  wire logic         sda_i,    // resolved data wire
   input  wire logic         sda_o,    // data out value
   input  wire logic         sda_oe_o, // data pull enable
   input  wire tsp_reg_req_s req_o,    // register request
   input  wire logic [7:0]   rdata_i,  // register read data
   input  wire logic         busy_o    // transfer in progress
);
   timeunit 1ns;
   timeprecision 1ps;
   // ********
   // bus checks
   // ********
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_start;
      scl_i && $fell(sda_i);
   endsequence
   sequence s_stop;
      scl_i && $rose(sda_i);
   endsequence
   wire any_req = req_o.wr | req_o.rd;

   a_sda_low_only: assert property (sda_o == 1'b0)
      else $error("sda value not low");
   a_idle_released: assert property (!busy_o |-> !sda_oe_o)
      else $error("sda pulled while idle");
   a_start_busy: assert property (s_start |-> ##[1:8] busy_o)
      else $error("start not seen");
   a_stop_free: assert property (s_stop |-> ##[1:8] !busy_o)
      else $error("stop not seen");
   a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("sda changed while scl high");
   a_ack_held: assert property ($rose(sda_oe_o) |-> sda_oe_o[*8])
      else $error("sda pull too short");
   a_wr_acked: assert property (req_o.wr |-> ##[0:4] sda_oe_o)
      else $error("written byte not acknowledged");
   a_req_pulse: assert property (any_req |=> !any_req)
      else $error("request longer than one cycle");
   a_req_single: assert property (!(req_o.wr && req_o.rd))
      else $error("read and write together");
   a_start_quiet: assert property (s_start |-> ##1 (!any_req)[*8])
      else $error("request right after start");
endmodule

bind tsp_slave_port tsp_props i_props (.mclk_i(mclk_i), .rstn_i(rstn_i),
   .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .req_o(req_o), .rdata_i(rdata_i), .busy_o(busy_o));

// ===== tsp_master.sv
/* bus master model: drives scl, pulls sda low or releases it.
 assumes sda is resolved with a pull-up outside this module. */
module tsp_master (
   input  wire logic mclk_i,   // core clock
   input  wire logic sda_i,    // resolved data wire
   output logic      scl_o,    // bus clock
   output logic      sda_oe_o  // high while pulling sda low
);
   timeunit 1ns;
   timeprecision 1ps;
   // ********
   // bus cycles, 160 ns scl period
   // ********
   // idle lines released
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   task automatic hp(input int n = 20);
      repeat (n) @(posedge mclk_i);
   endtask
   // one bit per pulse, 40 core cycles
   task automatic bit_io(input logic b, output logic r);
      hp(4);
      sda_oe_o <= ~b;
      hp(16);
      scl_o <= 1'b1;
      hp();
      r = sda_i;
      scl_o <= 1'b0;
   endtask
   task automatic start();
      hp(8);
      sda_oe_o <= 1'b0;
      hp();
      scl_o <= 1'b1;
      hp();
      sda_oe_o <= 1'b1;
      hp();
      scl_o <= 1'b0;
   endtask
   // stop frees the bus; scl lowered first
   task automatic stop();
      hp(8);
      scl_o <= 1'b0;
      hp(4);
      sda_oe_o <= 1'b1;
      hp();
      scl_o <= 1'b1;
      hp();
      sda_oe_o <= 1'b0;
      hp();
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic rbyte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(~ack, r);
   endtask
endmodule

// ===== testbench.sv
/* self-checking bench for the slave port with a bus master model.
 assumes a register file answering combinationally from req addr. */
module testbench
   import tsp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ********
   // bench
   // ********
   logic         mclk_i;
   logic         rstn_i;
   logic         scl;
   logic         m_oe;
   logic         s_oe;
   logic         busy;
   tsp_reg_req_s req;
   logic [7:0]   regs [256];
   logic [15:0]  wq [$];
   logic [7:0]   rq [$];
   logic [7:0]   d;
   int           fail_count;
   int           checked;
   int           cyc;
   wire          sda = ~(m_oe | s_oe);
   wire  [7:0]   rdata = regs[req.addr];

   tsp_slave_port i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .scl_i(scl),
      .sda_i(sda), .sda_o(), .sda_oe_o(s_oe), .req_o(req),
      .rdata_i(rdata), .busy_o(busy));
   tsp_master i_mst (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl),
      .sda_oe_o(m_oe));

   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (req.wr === 1'b1) wq.push_back({req.addr, req.wdata});
      if (req.rd === 1'b1) rq.push_back(req.addr);
      if (cyc == 40000) begin
         fail_count++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic put(input logic [7:0] v, input logic exp_ack);
      logic ack;
      i_mst.wbyte(v, ack);
      chk(16'(ack), 16'(exp_ack));
   endtask
   task automatic t_write();
      wq.delete();
      i_mst.start();
      chk(16'(busy), 16'h1);
      put(8'h6a, 1'b1);
      put(8'h10, 1'b1);
      put(8'hab, 1'b1);
      put(8'hcd, 1'b1);
      i_mst.stop();
      chk(16'(wq.size()), 16'h2);
      chk(wq[0], 16'h10ab);
      chk(wq[1], 16'h11cd);
      chk(16'(busy), 16'h0);
      $display("write test done");
   endtask
   task automatic t_read();
      wq.delete();
      rq.delete();
      i_mst.start();
      put(8'h6a, 1'b1);
      put(8'hff, 1'b1);
      i_mst.stop();
      chk(16'(wq.size()), 16'h0);
      i_mst.start();
      put(8'h6b, 1'b1);
      i_mst.rbyte(1'b1, d);
      chk(16'(d), 16'(8'hff ^ 8'h5a));
      i_mst.rbyte(1'b0, d);
      chk(16'(d), 16'(8'h00 ^ 8'h5a));
      chk(16'(rq.size()), 16'h2);
      chk(16'(rq[0]), 16'h00ff);
      chk(16'(rq[1]), 16'h0000);
      i_mst.hp(8);
      chk(16'(s_oe), 16'h0);
      i_mst.stop();
      $display("read test done");
   endtask
   task automatic t_restart();
      i_mst.start();
      put(8'h6a, 1'b1);
      put(8'h30, 1'b1);
      i_mst.start();
      put(8'h6b, 1'b1);
      i_mst.rbyte(1'b0, d);
      chk(16'(d), 16'(8'h30 ^ 8'h5a));
      i_mst.stop();
      $display("restart test done");
   endtask
   task automatic t_foreign();
      wq.delete();
      i_mst.start();
      put(8'h6c, 1'b0);
      put(8'h6a, 1'b0);
      i_mst.stop();
      chk(16'(wq.size()), 16'h0);
      $display("foreign test done");
   endtask

   initial begin
      rstn_i = 1'b0;
      for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'h5a;
      repeat (20) @(posedge mclk_i);
      rstn_i <= 1'b1;
      i_mst.stop();
      t_write();
      t_read();
      t_restart();
      t_foreign();
      test_done();
   end
endmodule
